// ==== hw/i2cs_port.sv ====
module i2cs_port #(
    parameter int unsigned FILT_CYC = i2cs_pkg::GLITCH_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus pins, sda open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // address straps
    input wire logic addr_strap_pin_0,
    input wire logic addr_strap_pin_1,
    input wire logic addr_strap_pin_2,
    // register write stream
    output logic wr_valid,
    input wire logic wr_ready,
    output logic [i2cs_pkg::PTR_W-1:0] wr_addr,
    output logic [7:0] wr_data,
    // register read port
    output logic rd_en,
    output logic [i2cs_pkg::PTR_W-1:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic rd_denied,
    // status
    output logic busy
);
    import i2cs_pkg::*;

    // filter plus edge logic must settle well inside a fast-mode half period
    initial begin
        if (FILT_CYC < 1 || (FILT_CYC + 6) >= FAST_HALF_CYC) begin
            $error("filter length does not fit the fast bus rate");
        end
    end

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;

    // scl is only ever sampled; no scl output exists
    i2cs_glitch_filter #(.STABLE_CYC(FILT_CYC)) u_scl_filt (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(scl_in),
        .level_out(scl_f)
    );

    i2cs_glitch_filter #(.STABLE_CYC(FILT_CYC)) u_sda_filt (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(sda_in),
        .level_out(sda_f)
    );

    wire scl_rise = scl_f & ~scl_q;
    wire scl_fall = ~scl_f & scl_q;
    wire start_det = scl_f & scl_q & sda_q & ~sda_f;
    wire stop_det = scl_f & scl_q & ~sda_q & sda_f;

    // strap capture after reset release
    logic [2:0] strap_s1_q;
    logic [2:0] strap_s2_q;
    logic [2:0] own_low_q;
    logic [1:0] strap_cnt_q;
    logic strap_done_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
            own_low_q <= 3'h0;
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
        end else begin
            strap_s1_q <= {addr_strap_pin_2, addr_strap_pin_1, addr_strap_pin_0};
            strap_s2_q <= strap_s1_q;
            if (!strap_done_q && strap_cnt_q == STRAP_SETTLE_CYC) begin
                own_low_q <= strap_s2_q;
                strap_done_q <= 1'b1;
            end else if (!strap_done_q) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
        end
    end

    i2cs_state_t state_q;
    i2cs_state_t state_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [7:0] rd_buf_q;
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic oe_q;
    logic oe_d;
    logic rd_en_q;
    logic rd_en_d;
    logic push;

    // write buffer, two entries of pointer and data
    logic [PTR_W+7:0] fifo_mem [2];
    logic fifo_wp_q;
    logic fifo_rp_q;
    logic [1:0] fifo_cnt_q;

    wire fifo_room = fifo_cnt_q != FIFO_DEPTH;
    wire pop = wr_valid & wr_ready;
    wire addr_match = strap_done_q && shift_q[7:1] == {SLAVE_ADDR_FIXED, own_low_q};
    wire bit_step = scl_rise && bit_cnt_q != BITS_PER_BYTE;
    wire byte_end = scl_fall && bit_cnt_q == BITS_PER_BYTE;

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        idx_d = idx_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        rd_en_d = 1'b0;
        push = 1'b0;
        if (start_det) begin
            // repeated start allowed anywhere; the partial byte is dropped
            state_d = I2CS_ADDR;
            bit_cnt_d = 4'h0;
            idx_d = IDX_PTR_HI;
            oe_d = 1'b0;
        end else if (stop_det) begin
            state_d = I2CS_IDLE;
            oe_d = 1'b0;
        end else begin
            case (state_q)
                I2CS_ADDR, I2CS_RX: begin
                    if (bit_step) begin
                        shift_d = {shift_q[6:0], sda_f};
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end else if (byte_end && state_q == I2CS_ADDR) begin
                        bit_cnt_d = 4'h0;
                        if (addr_match) begin
                            state_d = I2CS_ADDR_ACK;
                            rw_d = shift_q[0];
                            oe_d = 1'b1;
                        end else begin
                            state_d = I2CS_IDLE;
                        end
                    end else if (byte_end) begin
                        bit_cnt_d = 4'h0;
                        state_d = I2CS_RX_ACK;
                        if (idx_q == IDX_PTR_HI) begin
                            ptr_d[15:8] = shift_q;
                            idx_d = IDX_PTR_LO;
                            oe_d = 1'b1;
                        end else if (idx_q == IDX_PTR_LO) begin
                            ptr_d[7:0] = shift_q;
                            idx_d = IDX_DATA;
                            oe_d = 1'b1;
                        end else if (fifo_room) begin
                            push = 1'b1;
                            ptr_d = ptr_q + 16'h1;
                            oe_d = 1'b1;
                        end
                    end
                end
                I2CS_ADDR_ACK, I2CS_TX_ACK: begin
                    if (scl_rise && state_q == I2CS_TX_ACK && sda_f) begin
                        state_d = I2CS_IDLE;
                    end else if (scl_rise && (rw_q || state_q == I2CS_TX_ACK)) begin
                        rd_en_d = 1'b1;
                    end else if (scl_fall && rw_q) begin
                        state_d = I2CS_TX;
                        tx_d = rd_buf_q;
                        oe_d = ~rd_buf_q[7];
                        ptr_d = ptr_q + 16'h1;
                        bit_cnt_d = 4'h1;
                    end else if (scl_fall) begin
                        state_d = I2CS_RX;
                        oe_d = 1'b0;
                    end
                end
                I2CS_RX_ACK: begin
                    if (scl_fall) begin
                        // a refused byte leaves the device idle until the next start
                        state_d = oe_q ? I2CS_RX : I2CS_IDLE;
                        oe_d = 1'b0;
                    end
                end
                I2CS_TX: begin
                    if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
                        state_d = I2CS_TX_ACK;
                        oe_d = 1'b0;
                        bit_cnt_d = 4'h0;
                    end else if (scl_fall) begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = ~tx_q[6];
                        bit_cnt_d = bit_cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_d = I2CS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= I2CS_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            idx_q <= IDX_PTR_HI;
            ptr_q <= PTR_RESET;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            rd_en_q <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            idx_q <= idx_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            rd_en_q <= rd_en_d;
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // denied or missing registers read as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_buf_q <= 8'h00;
        end else if (rd_en_q) begin
            rd_buf_q <= rd_denied ? DENIED_BYTE : rd_data;
        end
    end

    // data bytes are acked only with room, so a stalled register side costs a nack, never a word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fifo_wp_q <= 1'b0;
            fifo_rp_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
        end else begin
            if (push) begin
                fifo_mem[fifo_wp_q] <= {ptr_q, shift_q};
                fifo_wp_q <= ~fifo_wp_q;
            end
            if (pop) begin
                fifo_rp_q <= ~fifo_rp_q;
            end
            fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    assign wr_valid = fifo_cnt_q != 2'h0;
    assign wr_addr = fifo_mem[fifo_rp_q][PTR_W+7:8];
    assign wr_data = fifo_mem[fifo_rp_q][7:0];
    assign rd_en = rd_en_q;
    assign rd_addr = ptr_q;
    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign busy = state_q != I2CS_IDLE;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_addr_done;
        state_q == I2CS_ADDR && byte_end;
    endsequence

    sequence s_master_nack;
        state_q == I2CS_TX_ACK && scl_rise && sda_f && !start_det && !stop_det;
    endsequence

    addr_mismatch_idle_a: assert property (s_addr_done and (!addr_match && !start_det && !stop_det)
        |=> state_q == I2CS_IDLE && !sda_oe)
        else $error("mismatched address was not ignored");

    addr_ack_drive_a: assert property (s_addr_done and (addr_match && !start_det && !stop_det)
        |=> state_q == I2CS_ADDR_ACK && sda_oe)
        else $error("matched address was not acknowledged");

    start_abort_a: assert property (start_det |=> state_q == I2CS_ADDR && bit_cnt_q == 4'h0 && !sda_oe)
        else $error("start did not restart byte reception");

    stop_release_a: assert property (stop_det && !start_det |=> state_q == I2CS_IDLE && !sda_oe)
        else $error("stop did not release the bus");

    sda_change_low_a: assert property ($changed(oe_q) && !$past(start_det) && !$past(stop_det) |-> !scl_f)
        else $error("sda drive changed while scl high");

    nack_ends_read_a: assert property (s_master_nack |=> state_q == I2CS_IDLE ##1 !sda_oe)
        else $error("master nack did not end the read");

    ptr_hi_load_a: assert property (state_q == I2CS_RX && byte_end && idx_q == IDX_PTR_HI && !start_det
        && !stop_det |=> ptr_q[15:8] == $past(shift_q) && idx_q == IDX_PTR_LO)
        else $error("pointer high byte not loaded");

    push_advance_a: assert property (push |=> ptr_q == $past(ptr_q) + 16'h1 && wr_valid)
        else $error("pointer did not advance after a data byte");

    push_full_byte_a: assert property (push |-> bit_cnt_q == BITS_PER_BYTE && idx_q == IDX_DATA
        && fifo_room)
        else $error("partial or pointer byte forwarded as data");

    denied_zero_a: assert property (rd_en_q && rd_denied |=> rd_buf_q == DENIED_BYTE)
        else $error("denied register did not read as zero");
endmodule

// ==== hw/i2cs_pkg.sv ====
package i2cs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STD_RATE_KHZ = 100;
    localparam int unsigned FAST_RATE_KHZ = 400;
    localparam int unsigned GLITCH_NS = 50;
    localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAST_HALF_NS = 1000000 / (2 * FAST_RATE_KHZ);
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;
    localparam logic [3:0] SLAVE_ADDR_FIXED = 4'h9;
    localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;
    localparam int unsigned PTR_W = 16;
    localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] DENIED_BYTE = 8'h00;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;
    localparam logic [1:0] IDX_PTR_HI = 2'h0;
    localparam logic [1:0] IDX_PTR_LO = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    typedef enum logic [2:0] {
        I2CS_IDLE = 3'h0,
        I2CS_ADDR = 3'h1,
        I2CS_ADDR_ACK = 3'h3,
        I2CS_RX = 3'h2,
        I2CS_RX_ACK = 3'h6,
        I2CS_TX = 3'h7,
        I2CS_TX_ACK = 3'h5
    } i2cs_state_t;
endpackage

// ==== hw/i2cs_glitch_filter.sv ====
module i2cs_glitch_filter #(
    parameter int unsigned STABLE_CYC = i2cs_pkg::GLITCH_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pin side
    input wire logic pin_in,
    // filtered level
    output logic level_out
);
    import i2cs_pkg::*;

    localparam int unsigned CNT_W = $clog2(STABLE_CYC + 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(STABLE_CYC);

    initial begin
        if (STABLE_CYC < 1) begin
            $error("glitch filter needs at least one cycle");
        end
    end

    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic [CNT_W-1:0] cnt_q;

    // a change must persist for STABLE_CYC+1 samples, so a spike under the limit never passes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            level_q <= 1'b1;
            cnt_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            if (sync2_q == level_q) begin
                cnt_q <= '0;
            end else if (cnt_q == LIMIT) begin
                level_q <= sync2_q;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign level_out = level_q;
endmodule

// ==== tb/i2cs_master_model.sv ====
module i2cs_master_model (
    // pacing clock
    input wire logic sys_clk,
    // bus lines, sda_drv low pulls sda down
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    int half_cyc = 125;
    logic glitch = 1'b0;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // 40 ns spike, four sys_clk cycles, under the filter window
    task automatic spike_sda();
        sda_drv = 1'b0;
        tick(4);
        sda_drv = 1'b1;
    endtask
    task automatic bit_xfer(input logic b, output logic s);
        tick(half_cyc / 2);
        sda_drv = b;
        if (glitch) begin
            scl = 1'b1;
            tick(4);
            scl = 1'b0;
        end
        tick(half_cyc / 2);
        scl = 1'b1;
        tick(half_cyc / 2);
        s = sda_line;
        tick(half_cyc / 2);
        scl = 1'b0;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        tick(half_cyc / 2);
        scl = 1'b1;
        tick(half_cyc);
        sda_drv = 1'b0;
        tick(half_cyc);
        scl = 1'b0;
    endtask
    task automatic stop();
        tick(half_cyc / 2);
        sda_drv = 1'b0;
        tick(half_cyc / 2);
        scl = 1'b1;
        tick(half_cyc);
        sda_drv = 1'b1;
        tick(half_cyc);
    endtask
    task automatic byte_wr(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
        bit_xfer(1'b1, nack);
    endtask
    task automatic byte_rd(input logic last, output logic [7:0] d);
        logic b;
        for (int i = 0; i < 8; i++) begin
            bit_xfer(1'b1, b);
            d = {d[6:0], b};
        end
        bit_xfer(last, b);
    endtask
endmodule

// ==== tb/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import i2cs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic scl_m;
    logic sda_m;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
    logic [2:0] strap = 3'h0;
    logic wr_valid;
    logic wr_ready = 1'b0;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic rd_en;
    logic [15:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_denied;
    logic busy;
    logic stall = 1'b0;
    logic [6:0] dev;
    logic [23:0] exp_q[$];
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    int n_rd = 0;

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // pull-up on sda: low when either side pulls
    assign sda_in = sda_m & ~(sda_oe & ~sda_out);
    assign rd_denied = (rd_addr[15:12] == 4'hf);
    assign rd_data = reg_val(rd_addr);

    i2cs_port #(.FILT_CYC(GLITCH_CYC)) dut (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl_m), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_pin_0(strap[0]), .addr_strap_pin_1(strap[1]), .addr_strap_pin_2(strap[2]),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_denied(rd_denied), .busy(busy)
    );
    i2cs_master_model bus_master (.sys_clk(sys_clk), .scl(scl_m), .sda_drv(sda_m), .sda_line(sda_in));

    function automatic logic [7:0] reg_val(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [7:0] exp_val(input logic [15:0] a);
        return (a[15:12] == 4'hf) ? 8'h00 : reg_val(a);
    endfunction
    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic send(input logic [7:0] b, input logic exp_nack);
        logic nk;
        bus_master.byte_wr(b, nk);
        chk(nk, exp_nack, "ack bit");
    endtask
    task automatic set_ptr(input logic [15:0] p);
        bus_master.start();
        send({dev, 1'b0}, 1'b0);
        send(p[15:8], 1'b0);
        send(p[7:0], 1'b0);
    endtask
    task automatic put(input logic [15:0] a);
        logic [7:0] d;
        d = 8'($urandom);
        exp_q.push_back({a, d});
        send(d, 1'b0);
    endtask
    task automatic get(input logic [15:0] a, input int n);
        logic [7:0] d;
        int n0;
        n0 = n_rd;
        bus_master.start();
        send({dev, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            bus_master.byte_rd(i == n - 1, d);
            chk(d, exp_val(16'(a + i)), "read byte");
        end
        bus_master.stop();
        chk(24'(n_rd - n0), 24'(n), "read strobes");
    endtask

    // register side stalls at random so the buffer is exercised
    always @(posedge sys_clk) begin
        #1;
        wr_ready = !stall && ($urandom_range(1) == 1);
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (!rst && rd_en === 1'b1) begin
            n_rd++;
        end
        if (!rst && wr_valid === 1'b1 && wr_ready) begin
            if (exp_q.size() == 0) begin
                chk(24'h1, 24'h0, "unexpected register write");
            end else begin
                chk({wr_addr, wr_data}, exp_q.pop_front(), "write word");
            end
        end
        // the scenarios need about 97k cycles
        if (cyc == 100000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        logic s;
        void'($urandom(32'h4773c13a));
        strap = 3'($urandom);
        dev = {SLAVE_ADDR_FIXED, strap};
        repeat (10) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        bus_master.tick(20);
        bus_master.spike_sda();
        // a spike that got through would show busy for only a few cycles
        for (int i = 0; i < 20; i++) begin
            bus_master.tick(1);
            chk(busy, 1'b0, "busy after spike");
        end
        bus_master.start();
        send({dev ^ 7'h01, 1'b0}, 1'b1);
        bus_master.tick(20);
        chk(busy, 1'b0, "busy after mismatch");
        bus_master.stop();
        // top of the pointer range, wrap, scl spikes, repeated start
        set_ptr(16'hfffe);
        put(16'hfffe);
        bus_master.glitch = 1'b1;
        put(16'hffff);
        bus_master.glitch = 1'b0;
        put(16'h0000);
        get(16'h0001, 2);
        set_ptr(16'h1234);
        bus_master.stop();
        get(16'h1234, 1);
        set_ptr(16'hf001);
        get(16'hf001, 1);
        // half a byte then stop: dropped, pointer kept
        set_ptr(16'h0040);
        for (int i = 0; i < 4; i++) bus_master.bit_xfer(1'(i), s);
        bus_master.stop();
        get(16'h0040, 1);
        // two words fill the buffer, the third is refused
        stall = 1'b1;
        set_ptr(16'h0200);
        put(16'h0200);
        put(16'h0201);
        send(8'h5a, 1'b1);
        bus_master.stop();
        stall = 1'b0;
        bus_master.tick(40);
        chk(24'(exp_q.size()), 24'h0, "words left");
        bus_master.half_cyc = 500;
        get(16'h0202, 1);
        wrap_up();
    end
endmodule
